// [rtl/mcfm_pkg.sv]
// shared constants and state type for the multi-channel fault manager
package mcfm_pkg;

  localparam int NCH = 4;
  localparam int NLINE = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_CLEAR = 8'h08;
  localparam logic [7:0] OFS_GLOBAL_CFG = 8'h0c;
  localparam logic [7:0] OFS_CHANNEL_CFG = 8'h10;
  localparam logic [7:0] OFS_AUX_CFG_A = 8'h14;
  localparam logic [7:0] OFS_AUX_CFG_B = 8'h18;
  localparam logic [7:0] OFS_PROPAGATE = 8'h1c;
  localparam logic [7:0] OFS_RESPONSE = 8'h20;
  localparam logic [7:0] OFS_PG_MAP = 8'h24;
  localparam logic [7:0] OFS_LIVE = 8'h28;

  // status layout, four bits per warning and fault group, one per channel; the line group has two bits, one per line
  localparam int ST_OVW_LSB = 0;
  localparam int ST_UVW_LSB = 4;
  localparam int ST_OCW_LSB = 8;
  localparam int ST_OVF_LSB = 12;
  localparam int ST_OCF_LSB = 16;
  localparam int ST_UCF_LSB = 20;
  localparam int ST_LINE_LSB = 24;
  localparam int ST_W = 26;

  // configuration field positions
  localparam int GCFG_SHARE_BIT = 0;
  localparam int CHCFG_POL_LSB = 0;
  localparam int CHCFG_FS_LSB = 4;
  localparam int AUXA_OV_LSB = 0;
  localparam int AUXA_OC_LSB = 4;
  localparam int AUXB_UC_LSB = 0;
  localparam int LIVE_LINE_LSB = 0;
  localparam int LIVE_SHUT_LSB = 2;
  localparam int LIVE_AUX_BIT = 6;
  localparam int LIVE_PG_BIT = 7;

  // reset values
  localparam logic GCFG_RST = 1'b1;
  localparam logic [3:0] PG_MAP_RST = 4'hf;

  // timing
  localparam int CLK_MHZ = 200;
  localparam int DEGLITCH_NS = 10000;
  localparam int RESET_PULSE_MIN_NS = 1000;
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] DG_CYC = CNT_W'((DEGLITCH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] RST_CYC = CNT_W'((RESET_PULSE_MIN_NS * CLK_MHZ + 999) / 1000);

  typedef struct packed {
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic gcfg;
    logic [7:0] chcfg;
    logic [7:0] auxa;
    logic [3:0] auxb;
    logic [2*NCH-1:0] prop;
    logic [2*NCH-1:0] resp;
    logic [NCH-1:0] pgmap;
    logic [NLINE-1:0][CNT_W-1:0] dg_cnt;
    logic [NLINE-1:0] line_dg;
    logic [NLINE-1:0] line_drv;
    logic [NCH-1:0] shut;
    logic [NCH-1:0] held;
    logic [NCH-1:0] restart;
    logic aux_latch;
    logic pg;
    logic [CNT_W-1:0] wd_cnt;
    logic [DATA_W-1:0] rdata;
  } mcfm_state_t;

endpackage

// [rtl/mcfm_fault_manager.sv]
// fault coordination, warnings, aux fault, power good and register file
// Contract
// RULE1: warnings come from measured-reading comparisons, not from the fast supervisors.
// RULE2: there is no undercurrent warning, undercurrent exists only as a fault.
// RULE3: any warning sets its status bit and pulls the alert output low.
// RULE4: a warning never removes a channel's converter enable; only fault responses do.
// RULE5: aux fault output goes low on ov, oc or uc faults, each gated by its select bit.
// RULE6: aux fault output is released when a channel is commanded back to the on state.
// RULE7: a per-channel propagate map picks the shared lines pulled low while that channel is faulted off.
// RULE8: a per-channel response map picks the shared lines that shut that channel down.
// RULE9: a channel shut down by a shared line restarts once that line is released.
// RULE10: a low on a shared line is deglitched for 10 us before the responding channels turn off.
// RULE11: the watchdog/reset pin held low for the minimum pulse time forces the power-on reset state.
// RULE12: power good combines only the channels enabled in the power-good channel map.
// RULE13: the input share sync enable bit is set by default so sequencing on vin thresholds is shared.
// RULE14: the dac polarity bit is 0 for feedback-resistor converters and 1 for trim-pin converters.
// RULE15: the trim dac offers exactly two full-scale settings, one select bit per channel.
// RULE16: a clear-faults command clears the status register and releases the alert output.
// RULE17: shared lines are open-drain, so the pin level is sampled apart from our own drive.
`timescale 1ns/1ps

module mcfm_fault_manager (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic [mcfm_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [mcfm_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [mcfm_pkg::DATA_W-1:0] reg_rdata_out,
  output logic irq_out,
  input wire logic [mcfm_pkg::NCH-1:0] meas_ov_warn_in,
  input wire logic [mcfm_pkg::NCH-1:0] meas_uv_warn_in,
  input wire logic [mcfm_pkg::NCH-1:0] meas_oc_warn_in,
  input wire logic [mcfm_pkg::NCH-1:0] ov_fault_in,
  input wire logic [mcfm_pkg::NCH-1:0] oc_fault_in,
  input wire logic [mcfm_pkg::NCH-1:0] uc_fault_in,
  input wire logic [mcfm_pkg::NCH-1:0] faulted_off_in,
  input wire logic [mcfm_pkg::NCH-1:0] on_cmd_in,
  input wire logic [mcfm_pkg::NCH-1:0] ch_good_in,
  input wire logic [mcfm_pkg::NLINE-1:0] shared_fault_line_n_in,
  output logic [mcfm_pkg::NLINE-1:0] shared_fault_line_n_out,
  output logic [mcfm_pkg::NLINE-1:0] shared_fault_line_n_oe_out,
  input wire logic watchdog_in_reset_n_in,
  output logic alert_out_n,
  output logic aux_fault_out_n,
  output logic power_good_out,
  output logic [mcfm_pkg::NCH-1:0] ch_shutdown_out,
  output logic [mcfm_pkg::NCH-1:0] ch_restart_out,
  output logic por_out,
  output logic vin_share_sync_en_out,
  output logic [mcfm_pkg::NCH-1:0] dac_pol_out,
  output logic [mcfm_pkg::NCH-1:0] dac_fs_sel_out
);

  ////////////////////////////////////////////////////////////////////////
  // reset image and helpers

  localparam mcfm_pkg::mcfm_state_t ST_RST = '{
    gcfg: mcfm_pkg::GCFG_RST,
    pgmap: mcfm_pkg::PG_MAP_RST,
    default: '0
  };

  // saturating counter step, shared by deglitch and watchdog timers
  function automatic logic [mcfm_pkg::CNT_W-1:0] sat_inc(
    input logic [mcfm_pkg::CNT_W-1:0] v,
    input logic [mcfm_pkg::CNT_W-1:0] lim
  );
    logic [mcfm_pkg::CNT_W-1:0] r;
    r = v;
    if (v < lim) begin
      r = v + mcfm_pkg::CNT_W'(1);
    end
    return r;
  endfunction

  // lines selected for one channel out of a flat two-bit-per-channel map
  function automatic logic [mcfm_pkg::NLINE-1:0] ch_lines(
    input logic [2*mcfm_pkg::NCH-1:0] map,
    input int ch
  );
    return map[ch*mcfm_pkg::NLINE +: mcfm_pkg::NLINE];
  endfunction

  mcfm_pkg::mcfm_state_t q;
  mcfm_pkg::mcfm_state_t n;

  ////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    logic [mcfm_pkg::ST_W-1:0] set_v;
    logic [mcfm_pkg::ST_W-1:0] clr_v;
    logic [mcfm_pkg::NLINE-1:0] low_raw;
    logic [mcfm_pkg::NCH-1:0] shut_now;
    logic aux_set;
    logic [mcfm_pkg::DATA_W-1:0] rd_v;
    set_v = '0;
    clr_v = '0;
    low_raw = '0;
    shut_now = '0;
    aux_set = 1'b0;
    rd_v = '0;
    n = q;

    // pin level taken as-is, never masked by our own pull-down
    low_raw = ~shared_fault_line_n_in; // [RULE17]

    // deglitch: the line counts as low only after a full run of low samples
    for (int l = 0; l < mcfm_pkg::NLINE; l++) begin
      if (low_raw[l]) begin
        n.dg_cnt[l] = sat_inc(q.dg_cnt[l], mcfm_pkg::DG_CYC); // [RULE10]
      end else begin
        n.dg_cnt[l] = '0;
      end
      n.line_dg[l] = (n.dg_cnt[l] == mcfm_pkg::DG_CYC); // [RULE10]
    end

    // pull lines for faulted-off channels and answer lines per response map
    n.line_drv = '0;
    for (int c = 0; c < mcfm_pkg::NCH; c++) begin
      if (faulted_off_in[c]) begin
        n.line_drv = n.line_drv | ch_lines(q.prop, c); // [RULE7]
      end
      shut_now[c] = |(ch_lines(q.resp, c) & q.line_dg); // [RULE8] [RULE10]
    end
    // shutdown follows fault lines only; warnings never reach it
    n.shut = shut_now; // [RULE4]
    // a held channel restarts as soon as none of its lines stays low
    n.restart = q.held & ~shut_now; // [RULE9]
    n.held = shut_now;

    // events: measured warnings (no undercurrent warning exists), faults, line lows
    set_v[mcfm_pkg::ST_OVW_LSB +: mcfm_pkg::NCH] = meas_ov_warn_in; // [RULE1] [RULE3]
    set_v[mcfm_pkg::ST_UVW_LSB +: mcfm_pkg::NCH] = meas_uv_warn_in; // [RULE1] [RULE3]
    set_v[mcfm_pkg::ST_OCW_LSB +: mcfm_pkg::NCH] = meas_oc_warn_in; // [RULE1] [RULE2]
    set_v[mcfm_pkg::ST_OVF_LSB +: mcfm_pkg::NCH] = ov_fault_in;
    set_v[mcfm_pkg::ST_OCF_LSB +: mcfm_pkg::NCH] = oc_fault_in;
    set_v[mcfm_pkg::ST_UCF_LSB +: mcfm_pkg::NCH] = uc_fault_in;
    set_v[mcfm_pkg::ST_LINE_LSB +: mcfm_pkg::NLINE] = n.line_dg & ~q.line_dg;

    // aux fault: selected faults latch it, an on command releases it
    aux_set = |((ov_fault_in & q.auxa[mcfm_pkg::AUXA_OV_LSB +: mcfm_pkg::NCH])
              | (oc_fault_in & q.auxa[mcfm_pkg::AUXA_OC_LSB +: mcfm_pkg::NCH])
              | (uc_fault_in & q.auxb[mcfm_pkg::AUXB_UC_LSB +: mcfm_pkg::NCH])); // [RULE5]
    if (aux_set) begin
      n.aux_latch = 1'b1; // [RULE5]
    end else if (|on_cmd_in) begin
      n.aux_latch = 1'b0; // [RULE6]
    end

    // power good over mapped channels only; an empty map reads good
    n.pg = &(ch_good_in | ~q.pgmap); // [RULE12]

    // register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        mcfm_pkg::OFS_STATUS: begin
          clr_v = reg_wdata_in[mcfm_pkg::ST_W-1:0];
        end
        mcfm_pkg::OFS_MASK: begin
          n.mask = reg_wdata_in[mcfm_pkg::ST_W-1:0];
        end
        mcfm_pkg::OFS_CLEAR: begin
          clr_v = '1; // [RULE16]
        end
        mcfm_pkg::OFS_GLOBAL_CFG: begin
          n.gcfg = reg_wdata_in[mcfm_pkg::GCFG_SHARE_BIT]; // [RULE13]
        end
        mcfm_pkg::OFS_CHANNEL_CFG: begin
          n.chcfg = reg_wdata_in[7:0]; // [RULE14] [RULE15]
        end
        mcfm_pkg::OFS_AUX_CFG_A: begin
          n.auxa = reg_wdata_in[7:0];
        end
        mcfm_pkg::OFS_AUX_CFG_B: begin
          n.auxb = reg_wdata_in[3:0];
        end
        mcfm_pkg::OFS_PROPAGATE: begin
          n.prop = reg_wdata_in[2*mcfm_pkg::NCH-1:0];
        end
        mcfm_pkg::OFS_RESPONSE: begin
          n.resp = reg_wdata_in[2*mcfm_pkg::NCH-1:0];
        end
        mcfm_pkg::OFS_PG_MAP: begin
          n.pgmap = reg_wdata_in[mcfm_pkg::NCH-1:0];
        end
        default: begin
        end
      endcase
    end

    // sticky status, a new event in the clearing cycle survives
    n.status = (q.status & ~clr_v) | set_v; // [RULE3] [RULE16]

    // read data valid in the cycle after the strobe only
    if (reg_rd_in) begin
      case (reg_addr_in)
        mcfm_pkg::OFS_STATUS: rd_v[mcfm_pkg::ST_W-1:0] = q.status;
        mcfm_pkg::OFS_MASK: rd_v[mcfm_pkg::ST_W-1:0] = q.mask;
        mcfm_pkg::OFS_GLOBAL_CFG: rd_v[mcfm_pkg::GCFG_SHARE_BIT] = q.gcfg;
        mcfm_pkg::OFS_CHANNEL_CFG: rd_v[7:0] = q.chcfg;
        mcfm_pkg::OFS_AUX_CFG_A: rd_v[7:0] = q.auxa;
        mcfm_pkg::OFS_AUX_CFG_B: rd_v[3:0] = q.auxb;
        mcfm_pkg::OFS_PROPAGATE: rd_v[2*mcfm_pkg::NCH-1:0] = q.prop;
        mcfm_pkg::OFS_RESPONSE: rd_v[2*mcfm_pkg::NCH-1:0] = q.resp;
        mcfm_pkg::OFS_PG_MAP: rd_v[mcfm_pkg::NCH-1:0] = q.pgmap;
        mcfm_pkg::OFS_LIVE: begin
          rd_v[mcfm_pkg::LIVE_LINE_LSB +: mcfm_pkg::NLINE] = q.line_dg;
          rd_v[mcfm_pkg::LIVE_SHUT_LSB +: mcfm_pkg::NCH] = q.shut;
          rd_v[mcfm_pkg::LIVE_AUX_BIT] = q.aux_latch;
          rd_v[mcfm_pkg::LIVE_PG_BIT] = q.pg;
        end
        default: rd_v = '0; // unmapped and clear register read zero
      endcase
    end
    n.rdata = rd_v;

    // watchdog/reset pin: a long enough low forces the reset image
    if (!watchdog_in_reset_n_in) begin
      n.wd_cnt = sat_inc(q.wd_cnt, mcfm_pkg::RST_CYC); // [RULE11]
    end else begin
      n.wd_cnt = '0;
    end
    if (q.wd_cnt == mcfm_pkg::RST_CYC) begin
      // hold everything at reset while the pin stays low
      n = ST_RST; // [RULE11]
      n.wd_cnt = q.wd_cnt;
      if (watchdog_in_reset_n_in) begin
        n.wd_cnt = '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; clock enable freezes every field

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= ST_RST;
    end else if (ce_in) begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // open-drain lines: drive low only, enable marks the pull
  assign shared_fault_line_n_out = '0; // [RULE17]
  assign shared_fault_line_n_oe_out = q.line_drv; // [RULE7]
  // alert stays low while any status bit is set
  assign alert_out_n = ~|q.status; // [RULE3] [RULE16]
  assign irq_out = |(q.status & q.mask);
  assign aux_fault_out_n = ~q.aux_latch; // [RULE5] [RULE6]
  assign power_good_out = q.pg; // [RULE12]
  assign ch_shutdown_out = q.shut; // [RULE8]
  assign ch_restart_out = q.restart; // [RULE9]
  assign por_out = (q.wd_cnt == mcfm_pkg::RST_CYC); // [RULE11]
  assign vin_share_sync_en_out = q.gcfg; // [RULE13]
  // polarity 0 suits feedback resistors, 1 suits a trim pin
  assign dac_pol_out = q.chcfg[mcfm_pkg::CHCFG_POL_LSB +: mcfm_pkg::NCH]; // [RULE14]
  // one bit per channel: 0 picks the low full scale, 1 the high one
  assign dac_fs_sel_out = q.chcfg[mcfm_pkg::CHCFG_FS_LSB +: mcfm_pkg::NCH]; // [RULE15]
  assign reg_rdata_out = q.rdata;

endmodule

// [verif/mcfm_peer_model.sv]
// far side of the shared fault lines: open-drain pull-downs with pull-ups
`timescale 1ns/1ps
module mcfm_peer_model (
  input wire logic [1:0] oe_in,
  input wire logic [1:0] ext_pull_in,
  output logic [1:0] line_n_out
);
  // a released line floats to the pull-up level; a peer pulls only when told
  assign line_n_out = ~(oe_in | ext_pull_in);
endmodule

// [verif/mcfm_checker.sv]
// port assertions for the fault manager
`timescale 1ns/1ps
module mcfm_checker (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic [3:0] meas_ov_warn_in,
  input wire logic [3:0] ov_fault_in,
  input wire logic [3:0] oc_fault_in,
  input wire logic [3:0] uc_fault_in,
  input wire logic [3:0] faulted_off_in,
  input wire logic [3:0] on_cmd_in,
  input wire logic [1:0] shared_fault_line_n_in,
  input wire logic [1:0] shared_fault_line_n_oe_out,
  input wire logic watchdog_in_reset_n_in,
  input wire logic alert_out_n,
  input wire logic aux_fault_out_n,
  input wire logic [3:0] ch_shutdown_out,
  input wire logic [3:0] ch_restart_out,
  input wire logic por_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////
  // low-sample runs; saturating so a long hold never wraps back under a limit
  logic [2:0][11:0] run;
  wire logic [2:0] hi = {watchdog_in_reset_n_in, shared_fault_line_n_in};
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    for (int j = 0; j < 3; j++) begin
      if (!rst_b_in || hi[j]) begin
        run[j] <= 12'h000;
      end else if (ce_in && run[j] != 12'hfff) begin
        run[j] <= run[j] + 12'h001;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  chk_warn_alert: assert property (
    ce_in && !por_out && watchdog_in_reset_n_in && |meas_ov_warn_in |=> !alert_out_n)
    else $error("warning left alert high");
  chk_shut_deglitch: assert property (
    (ch_shutdown_out & ~$past(ch_shutdown_out)) != 4'h0 |->
    run[0] >= {1'b0, mcfm_pkg::DG_CYC} || run[1] >= {1'b0, mcfm_pkg::DG_CYC})
    else $error("shutdown before deglitch");
  chk_aux_cause: assert property ($fell(aux_fault_out_n) |->
    $past(|(ov_fault_in | oc_fault_in | uc_fault_in))) else $error("aux low without fault");
  chk_aux_release: assert property ($rose(aux_fault_out_n) |->
    $past(|on_cmd_in) || $past(por_out)) else $error("aux released without on command");
  chk_oe_cause: assert property (
    |shared_fault_line_n_oe_out && $past(ce_in) |-> $past(|faulted_off_in))
    else $error("line pulled without faulted channel");
  chk_restart_cause: assert property ($past(ce_in) |->
    (ch_restart_out & ~$past(ch_shutdown_out)) == 4'h0) else $error("restart without shutdown");
  chk_restart_pulse: assert property ($past(ce_in) |->
    (ch_restart_out & $past(ch_restart_out)) == 4'h0) else $error("restart longer than a cycle");
  chk_por_width: assert property (
    $rose(por_out) |-> run[2] >= {1'b0, mcfm_pkg::RST_CYC}) else $error("reset pulse too short");
endmodule
bind mcfm_fault_manager mcfm_checker i_chk (.clk_in, .rst_b_in, .ce_in, .meas_ov_warn_in,
  .ov_fault_in, .oc_fault_in, .uc_fault_in, .faulted_off_in, .on_cmd_in,
  .shared_fault_line_n_in, .shared_fault_line_n_oe_out, .watchdog_in_reset_n_in,
  .alert_out_n, .aux_fault_out_n, .ch_shutdown_out, .ch_restart_out, .por_out);

// [verif/tb.sv]
// self-checking bench for the fault manager
`timescale 1ns/1ps
module tb;
  logic clk_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic watchdog_in_reset_n_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, v;
  logic [3:0] meas_ov_warn_in = 4'h0, meas_uv_warn_in = 4'h0, meas_oc_warn_in = 4'h0;
  logic [3:0] ov_fault_in = 4'h0, oc_fault_in = 4'h0, uc_fault_in = 4'h0, ch_good_in = 4'h0;
  logic [3:0] faulted_off_in = 4'h0, on_cmd_in = 4'h0, ch_shutdown_out, ch_restart_out;
  logic [3:0] dac_pol_out, dac_fs_sel_out;
  logic [1:0] ext = 2'h0, shared_fault_line_n_in, shared_fault_line_n_oe_out;
  logic irq_out, alert_out_n, aux_fault_out_n, power_good_out, por_out, vin_share_sync_en_out;
  logic [11:0] fv [3] = '{12'h010, 12'h002, 12'h100};
  int n_fail = 0, checked = 0, cyc = 0;
  mcfm_fault_manager i_dut (.clk_in, .rst_b_in, .ce_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out, .meas_ov_warn_in, .meas_uv_warn_in,
    .meas_oc_warn_in, .ov_fault_in, .oc_fault_in, .uc_fault_in, .faulted_off_in, .on_cmd_in,
    .ch_good_in, .shared_fault_line_n_in, .shared_fault_line_n_out(),
    .shared_fault_line_n_oe_out, .watchdog_in_reset_n_in, .alert_out_n, .aux_fault_out_n,
    .power_good_out, .ch_shutdown_out, .ch_restart_out, .por_out, .vin_share_sync_en_out,
    .dac_pol_out, .dac_fs_sel_out);
  mcfm_peer_model i_peer (.oe_in(shared_fault_line_n_oe_out), .ext_pull_in(ext),
    .line_n_out(shared_fault_line_n_in));
  always #2.5 clk_in = ~clk_in;
  // hang guard: the run needs about 2600 cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // one bus cycle; a read compares the word standing in the cycle after the strobe
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input string n);
    @(posedge clk_in);
    {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} <= {w, !w, a, d};
    @(posedge clk_in);
    {reg_wr_in, reg_rd_in} <= 2'h0;
    #1;
    if (!w) chk(n, d, reg_rdata_out);
  endtask
  task automatic restart(input logic [3:0] e);
    for (int k = 0; k < 12 && ch_restart_out !== e; k++) tick(1);
    chk("restart", e, ch_restart_out);
  endtask
  // status image of ov, uv, oc warnings and uc faults packed in w
  function automatic logic [31:0] exp_st(input logic [15:0] w);
    exp_st = {8'h00, w[3:0], 8'h00, w[7:4], w[11:8], w[15:12]};
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    v = $urandom(32'hff29);
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    bus(1'b0, mcfm_pkg::OFS_GLOBAL_CFG, 32'h1, "global_config");
    chk("share_sync", 1'b1, vin_share_sync_en_out);
    bus(1'b0, mcfm_pkg::OFS_PG_MAP, 32'hf, "pg_map");
    bus(1'b0, 8'h3c, 32'h0, "unmapped");
    $display("reset test done");
    // random warnings and uc faults, cleared alternately by w1c and clear-faults
    for (int i = 0; i < 4; i++) begin
      v = $urandom | 32'h1111;
      @(posedge clk_in);
      {meas_ov_warn_in, meas_uv_warn_in, meas_oc_warn_in, uc_fault_in} <= v[15:0];
      @(posedge clk_in);
      {meas_ov_warn_in, meas_uv_warn_in, meas_oc_warn_in, uc_fault_in} <= 16'h0;
      tick(1);
      chk("alert", 1'b0, alert_out_n);
      chk("warn_shut", 4'h0, ch_shutdown_out);
      bus(1'b0, mcfm_pkg::OFS_STATUS, exp_st(v[15:0]), "status");
      if (i[0]) begin
        bus(1'b1, mcfm_pkg::OFS_CLEAR, v, "");
      end else begin
        bus(1'b1, mcfm_pkg::OFS_MASK, 32'h1, "");
        chk("irq", 1'b1, irq_out);
        bus(1'b1, mcfm_pkg::OFS_STATUS, 32'hffffffff, "");
      end
      tick(1);
      chk("alert_clear", 1'b1, alert_out_n);
    end
    v = $urandom | 32'h1;
    bus(1'b1, mcfm_pkg::OFS_CHANNEL_CFG, v & 32'hff, "");
    chk("dac_pol", v[3:0], dac_pol_out);
    chk("dac_fs", v[7:4], dac_fs_sel_out);
    $display("warning test done");
    // unselected oc, selected uc and ov, each followed by an on command
    bus(1'b1, mcfm_pkg::OFS_AUX_CFG_A, 32'h1, "");
    bus(1'b1, mcfm_pkg::OFS_AUX_CFG_B, 32'h2, "");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      {ov_fault_in, oc_fault_in, uc_fault_in} <= fv[i];
      @(posedge clk_in);
      {ov_fault_in, oc_fault_in, uc_fault_in} <= 12'h0;
      tick(1);
      chk("aux_set", i == 0, aux_fault_out_n);
      @(posedge clk_in);
      on_cmd_in <= 4'h4;
      @(posedge clk_in);
      on_cmd_in <= 4'h0;
      tick(1);
      chk("aux_release", 1'b1, aux_fault_out_n);
    end
    $display("aux test done");
    // ch0 pulls line0, ch1 answers line0, ch2 answers line1 driven by a peer
    bus(1'b1, mcfm_pkg::OFS_PROPAGATE, 32'h1, "");
    bus(1'b1, mcfm_pkg::OFS_RESPONSE, 32'h24, "");
    @(posedge clk_in);
    ext <= 2'h2;
    repeat (300) @(posedge clk_in);
    ext <= 2'h0;
    tick(3);
    chk("glitch", 4'h0, ch_shutdown_out);
    @(posedge clk_in);
    faulted_off_in <= 4'h1;
    ext <= 2'h2;
    tick(2);
    chk("oe", 2'h1, shared_fault_line_n_oe_out);
    tick(1990);
    chk("early", 4'h0, ch_shutdown_out);
    for (int k = 0; k < 30 && ch_shutdown_out !== 4'h6; k++) tick(1);
    chk("shut", 4'h6, ch_shutdown_out);
    // both lines deglitched low, ch1 and ch2 shut, aux released, no channel good
    bus(1'b0, mcfm_pkg::OFS_LIVE, 32'h1b, "live");
    @(posedge clk_in);
    faulted_off_in <= 4'h0;
    restart(4'h2);
    chk("held", 4'h4, ch_shutdown_out);
    @(posedge clk_in);
    ext <= 2'h0;
    restart(4'h4);
    $display("line test done");
    bus(1'b1, mcfm_pkg::OFS_PG_MAP, 32'h3, "");
    @(posedge clk_in);
    ch_good_in <= {v[9:8], 2'h3};
    tick(2);
    chk("pg_on", 1'b1, power_good_out);
    @(posedge clk_in);
    ch_good_in <= 4'hd;
    watchdog_in_reset_n_in <= 1'b0;
    tick(2);
    chk("pg_off", 1'b0, power_good_out);
    tick(203);
    chk("por", 1'b1, por_out);
    chk("por_cfg", 4'h0, dac_pol_out);
    $display("power good and reset test done");
    conclude();
  end
endmodule
